//--- src/aicp_pkg.sv
/*
 * Shared constants and types of the converter two-wire control port.
 * Assumes a single 125 MHz system clock on both ends of the link.
 */
package aicp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus addresses
	localparam logic [6:0] DEV_ADDR = 7'h77;
	localparam logic [7:0] ADDR_WRITE = 8'hEE;
	localparam logic [7:0] ADDR_READ = 8'hEF;

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] REG_RES_HI = 8'hFD;
	localparam logic [7:0] REG_RES_LO = 8'hFE;
	localparam logic [7:0] REG_CFG = 8'hFF;

	////////////////////////////////////////////////////////////////////////
	// Config fields and reset values
	localparam int CFG_OSR_HI = 7;
	localparam int CFG_OSR_LO = 6;
	localparam int CFG_SCO = 5;
	localparam int CFG_DIV_DIS = 2;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int SYS_CLK_HZ = 125000000;
	localparam int SYS_CLK_MHZ = 125;
	localparam int SCL_MAX_HZ = 500000;
	localparam int SCL_QTR_CYC = (SYS_CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
	localparam int MCLK_HZ = 32768;
	localparam int MCLK_HALF_CYC = SYS_CLK_HZ / (2 * MCLK_HZ);
	localparam int RESET_PULSE_NS = 1000;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;

	////////////////////////////////////////////////////////////////////////
	// State types
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b010,
		ST_WRITE = 3'b011,
		ST_READ = 3'b100
	} aicp_dev_state_t;

	typedef enum logic [2:0] {
		H_RESET = 3'b000,
		H_IDLE = 3'b001,
		H_START = 3'b010,
		H_BYTE = 3'b011,
		H_STOP = 3'b100
	} aicp_host_state_t;

	////////////////////////////////////////////////////////////////////////
	// Internal clock ticks per conversion
	function automatic logic [9:0] aicp_osr_ticks(input logic [1:0] code);
		logic [9:0] t;
		t = 10'h040;
		case (code)
			2'b11: t = 10'h200;
			2'b01: t = 10'h100;
			2'b10: t = 10'h080;
			default: t = 10'h040;
		endcase
		return t;
	endfunction

endpackage

//--- src/aicp_if.sv
/*
 * Link between host and converter: open-drain serial pair plus side pins.
 * Assumes each party drives its own enables; wire levels resolve here.
 */
`timescale 1ns/1ps
interface aicp_if;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;
	logic mclk;
	logic master_reset_n;
	logic eoc;

	// Wired-AND of open-drain drivers
	assign scl = host_scl_oe_n | host_scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport dev(
		input scl, sda, mclk, master_reset_n,
		output dev_sda_o, dev_sda_oe_n, eoc
	);
	modport host(
		input scl, sda, eoc,
		output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n, mclk, master_reset_n
	);
endinterface

//--- src/aicp_device.sv
/*
 * Converter end: serial target, register file and conversion sequencer.
 * Assumes link pins synchronous to I_SYS_CLK and a well-behaved bus master.
 */
`timescale 1ns/1ps
module aicp_device import aicp_pkg::*; (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	// Link
	aicp_if.dev BUS,
	// Converter side
	input wire logic [15:0] I_SAMPLE,
	output logic [7:0] O_CONFIG,
	output logic O_CONV_BUSY
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	aicp_dev_state_t state_q;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	logic [7:0] ptr_q;
	logic rw_q;
	logic first_q;
	logic sda_oe_n_q;
	logic sda_o_q;
	logic scl_prev_q;
	logic sda_prev_q;
	logic mclk_prev_q;
	logic div_ph_q;
	logic busy_q;
	logic eoc_q;
	logic [9:0] cnt_q;
	logic [7:0] cfg_q;
	logic [15:0] result_q;
	logic mrst;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic cfg_wr;
	logic conv_start;
	logic tick;
	logic [7:0] rd_byte;

	function automatic logic [7:0] reg_read(input logic [7:0] ptr, input logic [15:0] res,
		input logic [7:0] cfg);
		logic [7:0] v;
		v = UNMAPPED_DATA;
		if (ptr == REG_RES_HI) begin
			v = res[15:8];
		end else if (ptr == REG_RES_LO) begin
			v = res[7:0];
		end else if (ptr == REG_CFG) begin
			v = cfg;
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Line events
	assign mrst = ~BUS.master_reset_n;
	assign scl_rise = BUS.scl & ~scl_prev_q;
	assign scl_fall = ~BUS.scl & scl_prev_q;
	assign start_det = BUS.scl & scl_prev_q & sda_prev_q & ~BUS.sda;
	assign stop_det = BUS.scl & scl_prev_q & ~sda_prev_q & BUS.sda;
	assign rd_byte = reg_read(ptr_q, result_q, cfg_q);
	assign cfg_wr = (state_q == ST_WRITE) & scl_fall & (bit_q == 4'h8) & ~first_q & (ptr_q == REG_CFG);
	assign conv_start = cfg_wr & shift_q[CFG_SCO];
	assign tick = (BUS.mclk & ~mclk_prev_q) & (cfg_q[CFG_DIV_DIS] | div_ph_q);

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			mclk_prev_q <= 1'b0;
		end else begin
			scl_prev_q <= BUS.scl;
			sda_prev_q <= BUS.sda;
			mclk_prev_q <= BUS.mclk;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial target
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_q <= ST_IDLE;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			ptr_q <= PTR_RESET;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (mrst) begin
			state_q <= ST_IDLE;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			ptr_q <= PTR_RESET;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (start_det) begin
			state_q <= ST_ADDR;
			bit_q <= 4'h0;
			sda_oe_n_q <= 1'b1;
		end else if (stop_det) begin
			state_q <= ST_IDLE;
			sda_oe_n_q <= 1'b1;
		end else begin
			case (state_q)
				ST_ADDR, ST_WRITE: begin
					if (scl_rise && bit_q != 4'h8) begin
						shift_q <= {shift_q[6:0], BUS.sda};
						bit_q <= bit_q + 4'h1;
					end else if (scl_fall && bit_q == 4'h8) begin
						bit_q <= 4'h0;
						if (state_q == ST_ADDR) begin
							if (shift_q[7:1] == DEV_ADDR) begin
								state_q <= ST_ACK;
								rw_q <= shift_q[0];
								first_q <= 1'b1;
								sda_oe_n_q <= 1'b0;
							end else begin
								state_q <= ST_IDLE;
							end
						end else begin
							if (first_q) begin
								ptr_q <= shift_q;
							end else begin
								ptr_q <= ptr_q + 8'h01;
							end
							first_q <= 1'b0;
							state_q <= ST_ACK;
							sda_oe_n_q <= 1'b0;
						end
					end
				end
				ST_ACK: begin
					if (scl_rise && rw_q && BUS.sda) begin
						state_q <= ST_IDLE;
					end else if (scl_fall) begin
						if (rw_q) begin
							state_q <= ST_READ;
							sda_oe_n_q <= rd_byte[7];
							shift_q <= {rd_byte[6:0], 1'b0};
							ptr_q <= ptr_q + 8'h01;
							bit_q <= 4'h1;
						end else begin
							state_q <= ST_WRITE;
							sda_oe_n_q <= 1'b1;
							bit_q <= 4'h0;
						end
					end
				end
				ST_READ: begin
					if (scl_fall) begin
						if (bit_q == 4'h8) begin
							state_q <= ST_ACK;
							sda_oe_n_q <= 1'b1;
						end else begin
							sda_oe_n_q <= shift_q[7];
							shift_q <= {shift_q[6:0], 1'b0};
							bit_q <= bit_q + 4'h1;
						end
					end
				end
				default: begin
					sda_oe_n_q <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sda_o_q <= 1'b0;
		end else begin
			sda_o_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Config register
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cfg_q <= CFG_RESET;
		end else if (mrst) begin
			cfg_q <= CFG_RESET;
		end else if (cfg_wr) begin
			cfg_q <= shift_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			busy_q <= 1'b0;
			eoc_q <= 1'b0;
			cnt_q <= 10'h000;
			div_ph_q <= 1'b0;
			result_q <= RESULT_RESET;
		end else if (mrst) begin
			busy_q <= 1'b0;
			eoc_q <= 1'b0;
			cnt_q <= 10'h000;
			div_ph_q <= 1'b0;
			result_q <= RESULT_RESET;
		end else if (conv_start) begin
			busy_q <= 1'b1;
			eoc_q <= 1'b0;
			cnt_q <= 10'h000;
			div_ph_q <= 1'b0;
		end else if (cfg_wr) begin
			busy_q <= 1'b0;
		end else begin
			if (BUS.mclk && !mclk_prev_q) begin
				div_ph_q <= ~div_ph_q;
			end
			if (busy_q && tick) begin
				if (cnt_q == aicp_osr_ticks(cfg_q[CFG_OSR_HI:CFG_OSR_LO]) - 10'h001) begin
					busy_q <= 1'b0;
					eoc_q <= 1'b1;
					result_q <= I_SAMPLE;
				end else begin
					cnt_q <= cnt_q + 10'h001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign BUS.dev_sda_oe_n = sda_oe_n_q;
	assign BUS.dev_sda_o = sda_o_q;
	assign BUS.eoc = eoc_q;
	assign O_CONFIG = cfg_q;
	assign O_CONV_BUSY = busy_q;

endmodule

//--- src/aicp_host.sv
/*
 * Host end: bus master for config writes and result reads, master clock
 * source and power-up reset pulse. Assumes one command at a time.
 */
`timescale 1ns/1ps
module aicp_host import aicp_pkg::*; #(
	parameter int MCLK_HALF = MCLK_HALF_CYC
) (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	// Link
	aicp_if.host BUS,
	// Command port
	input wire logic I_CMD_VALID,
	input wire logic I_CMD_WRITE,
	input wire logic I_CMD_TWO,
	input wire logic [7:0] I_CMD_REG,
	input wire logic [7:0] I_CMD_WDATA,
	input wire logic I_MCLK_RUN,
	output logic O_CMD_READY,
	output logic O_CMD_DONE,
	output logic O_NACK,
	output logic [15:0] O_RDATA,
	output logic O_EOC
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	aicp_host_state_t state_q;
	logic [1:0] ph_q;
	logic [6:0] qcnt_q;
	logic [3:0] bit_q;
	logic [2:0] step_q;
	logic [7:0] sh_q;
	logic [7:0] rx_q;
	logic [7:0] reg_q;
	logic [7:0] wdata_q;
	logic wr_q;
	logic two_q;
	logic scl_oe_n_q;
	logic sda_oe_n_q;
	logic mrst_n_q;
	logic ready_q;
	logic done_q;
	logic nack_q;
	logic [15:0] rdata_q;
	logic eoc_q;
	logic eoc_prev_q;
	logic pend_q;
	logic mclk_q;
	logic [15:0] mcnt_q;
	logic qt;
	logic rxb;
	logic last;

	assign qt = (qcnt_q == 7'(SCL_QTR_CYC - 1)) | (state_q == H_RESET);
	assign rxb = step_q >= 3'h3;
	assign last = (step_q == 3'h4) | ((step_q == 3'h3) & ~two_q);

	////////////////////////////////////////////////////////////////////////
	// Master sequencer
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_q <= H_RESET;
			ph_q <= 2'h0;
			qcnt_q <= 7'h00;
			bit_q <= 4'h0;
			step_q <= 3'h0;
			sh_q <= 8'h00;
			rx_q <= 8'h00;
			reg_q <= 8'h00;
			wdata_q <= 8'h00;
			wr_q <= 1'b0;
			two_q <= 1'b0;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
			mrst_n_q <= 1'b0;
			ready_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			done_q <= 1'b0;
			qcnt_q <= (qt || state_q == H_IDLE) ? 7'h00 : qcnt_q + 7'h01;
			case (state_q)
				H_RESET: begin
					if (qcnt_q == 7'(RESET_PULSE_CYC - 1)) begin
						mrst_n_q <= 1'b1;
						state_q <= H_IDLE;
						ready_q <= 1'b1;
					end else begin
						qcnt_q <= qcnt_q + 7'h01;
					end
				end
				H_IDLE: begin
					if (I_CMD_VALID) begin
						state_q <= H_START;
						ready_q <= 1'b0;
						wr_q <= I_CMD_WRITE;
						two_q <= I_CMD_TWO;
						reg_q <= I_CMD_REG;
						wdata_q <= I_CMD_WDATA;
						step_q <= 3'h0;
						ph_q <= 2'h0;
						nack_q <= 1'b0;
						rdata_q <= 16'h0000;
					end
				end
				H_START: begin
					if (qt) begin
						ph_q <= ph_q + 2'h1;
						case (ph_q)
							2'h0: sda_oe_n_q <= 1'b1;
							2'h1: scl_oe_n_q <= 1'b1;
							2'h2: sda_oe_n_q <= 1'b0;
							default: begin
								scl_oe_n_q <= 1'b0;
								state_q <= H_BYTE;
								bit_q <= 4'h0;
								sh_q <= (step_q == 3'h0) ? ADDR_WRITE : ADDR_READ;
							end
						endcase
					end
				end
				H_BYTE: begin
					if (qt) begin
						ph_q <= ph_q + 2'h1;
						case (ph_q)
							2'h0: begin
								if (bit_q != 4'h8) begin
									sda_oe_n_q <= rxb | sh_q[7];
								end else begin
									sda_oe_n_q <= ~rxb | last;
								end
							end
							2'h1: scl_oe_n_q <= 1'b1;
							2'h2: begin
								if (bit_q != 4'h8 && rxb) begin
									rx_q <= {rx_q[6:0], BUS.sda};
								end else if (bit_q == 4'h8 && !rxb) begin
									nack_q <= nack_q | BUS.sda;
								end
							end
							default: begin
								scl_oe_n_q <= 1'b0;
								sh_q <= {sh_q[6:0], 1'b0};
								bit_q <= bit_q + 4'h1;
								if (bit_q == 4'h8) begin
									bit_q <= 4'h0;
									step_q <= step_q + 3'h1;
									if (rxb) begin
										rdata_q <= {rdata_q[7:0], rx_q};
									end
									if (step_q == 3'h0) begin
										sh_q <= reg_q;
									end else if (step_q == 3'h1 && wr_q) begin
										sh_q <= wdata_q;
									end else if (step_q == 3'h1) begin
										state_q <= H_START;
									end else if (step_q == 3'h2 && wr_q) begin
										state_q <= H_STOP;
									end else if (last) begin
										state_q <= H_STOP;
									end
								end
							end
						endcase
					end
				end
				H_STOP: begin
					if (qt) begin
						ph_q <= ph_q + 2'h1;
						case (ph_q)
							2'h0: sda_oe_n_q <= 1'b0;
							2'h1: scl_oe_n_q <= 1'b1;
							2'h2: sda_oe_n_q <= 1'b1;
							default: begin
								state_q <= H_IDLE;
								ready_q <= 1'b1;
								done_q <= 1'b1;
							end
						endcase
					end
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master clock and conversion tracking
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			eoc_q <= 1'b0;
			eoc_prev_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			eoc_q <= BUS.eoc;
			eoc_prev_q <= eoc_q;
			if (state_q == H_IDLE && I_CMD_VALID && I_CMD_WRITE && I_CMD_REG == REG_CFG
				&& I_CMD_WDATA[CFG_SCO]) begin
				pend_q <= 1'b1;
			end else if (eoc_q && !eoc_prev_q) begin
				pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mclk_q <= 1'b0;
			mcnt_q <= 16'h0000;
		end else if (I_MCLK_RUN || pend_q) begin
			if (mcnt_q == 16'(MCLK_HALF - 1)) begin
				mcnt_q <= 16'h0000;
				mclk_q <= ~mclk_q;
			end else begin
				mcnt_q <= mcnt_q + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign BUS.host_scl_o = 1'b0;
	assign BUS.host_sda_o = 1'b0;
	assign BUS.host_scl_oe_n = scl_oe_n_q;
	assign BUS.host_sda_oe_n = sda_oe_n_q;
	assign BUS.mclk = mclk_q;
	assign BUS.master_reset_n = mrst_n_q;
	assign O_CMD_READY = ready_q;
	assign O_CMD_DONE = done_q;
	assign O_NACK = nack_q;
	assign O_RDATA = rdata_q;
	assign O_EOC = eoc_q;

endmodule

//--- verif/aicp_link_properties.sv
/*
 * Concurrent checks on the host-to-converter link signals.
 * Assumes instantiation beside the link interface, clocked by the system clock.
 */
`timescale 1ns/1ps
module aicp_link_properties import aicp_pkg::*; (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	// Link signals
	input wire logic i_host_scl_o,
	input wire logic i_host_scl_oe_n,
	input wire logic i_host_sda_o,
	input wire logic i_host_sda_oe_n,
	input wire logic i_dev_sda_o,
	input wire logic i_dev_sda_oe_n,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_mclk,
	input wire logic i_master_reset_n,
	input wire logic i_eoc
);
	logic scl_p_q;
	logic sda_p_q;
	logic rw_q;
	logic [4:0] cnt_q;
	logic [6:0] sh_q;
	logic rise;
	logic frame;
	assign rise = i_scl && !scl_p_q;
	assign frame = i_scl && scl_p_q && (i_sda != sda_p_q);

	////////////////////////////////////////////////////////////////////////
	// Bit counter since last start or stop
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= i_scl;
			sda_p_q <= i_sda;
		end
	end
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cnt_q <= 5'h00;
		end else if (frame) begin
			cnt_q <= 5'h00;
		end else if (rise && cnt_q != 5'h1F) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sh_q <= 7'h00;
			rw_q <= 1'b0;
		end else if (rise && cnt_q < 5'h07) begin
			sh_q <= {sh_q[5:0], i_sda};
		end else if (rise && cnt_q == 5'h07) begin
			rw_q <= i_sda;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Properties
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_N);
	sequence s_start;
		i_scl && $past(i_scl) && $fell(i_sda);
	endsequence
	sequence s_stop;
		i_scl && $past(i_scl) && $rose(i_sda);
	endsequence
	sequence s_idle;
		(i_scl && i_sda) [*8];
	endsequence
	property p_start_hold;
		s_start |=> i_scl [*8];
	endproperty
	a_start_hold: assert property (p_start_hold)
		else $error("clock fell right after start");
	property p_stop_idle;
		s_stop |=> s_idle;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("bus not idle after stop");
	property p_dev_change_low;
		$changed(i_dev_sda_oe_n) |-> !i_scl && !$past(i_scl);
	endproperty
	a_dev_change_low: assert property (p_dev_change_low)
		else $error("target changed data while clock high");
	property p_addr;
		rise && cnt_q == 5'h07 |-> sh_q == DEV_ADDR;
	endproperty
	a_addr: assert property (p_addr)
		else $error("address byte mismatch");
	property p_addr_ack;
		rise && cnt_q == 5'h08 |-> !i_sda;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("address not acknowledged");
	property p_write_ack;
		rise && !rw_q && (cnt_q == 5'h11 || cnt_q == 5'h1A) |-> !i_sda;
	endproperty
	a_write_ack: assert property (p_write_ack)
		else $error("written byte not acknowledged");
	property p_pin_reset;
		!i_master_reset_n |=> i_dev_sda_oe_n && !i_eoc;
	endproperty
	a_pin_reset: assert property (p_pin_reset)
		else $error("target not reset by reset pin");
	property p_quiet_reset;
		!i_master_reset_n |-> i_scl && i_sda;
	endproperty
	a_quiet_reset: assert property (p_quiet_reset)
		else $error("bus used during reset pulse");
	property p_eoc_hold;
		$rose(i_eoc) |=> i_eoc [*8];
	endproperty
	a_eoc_hold: assert property (p_eoc_hold)
		else $error("end of conversion dropped");
	property p_open_drain;
		!i_host_scl_o && !i_host_sda_o && !i_dev_sda_o;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("line driver drives high");
	property p_eoc_on_tick;
		$rose(i_eoc) |-> $past(i_mclk) && !$past(i_mclk, 2);
	endproperty
	a_eoc_on_tick: assert property (p_eoc_on_tick)
		else $error("end of conversion not on master clock rise");
endmodule

//--- verif/testbench.sv
/*
 * Self-checking bench: host and converter joined by the link interface.
 * Assumes 125 MHz clock, host master clock shortened to 4 cycles a half.
 */
`timescale 1ns/1ps
module testbench import aicp_pkg::*;;
	localparam int MH = 4;
	localparam int TAIL = 8 * SCL_QTR_CYC;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rst_h_n = 1'b0;
	logic valid = 1'b0;
	logic wr = 1'b0;
	logic two = 1'b0;
	logic run = 1'b0;
	logic [7:0] creg = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [15:0] sample = 16'h0000;
	logic ready, done, nack, eoc_h, busy;
	logic [15:0] rdata;
	logic [7:0] cfg;
	int error_cnt = 0;
	int n_compared = 0;
	aicp_if link_if();
	aicp_device aicp_device_inst(.I_SYS_CLK(clk), .I_RST_N(rst_n), .BUS(link_if.dev), .I_SAMPLE(sample),
		.O_CONFIG(cfg), .O_CONV_BUSY(busy));
	aicp_host #(.MCLK_HALF(MH)) aicp_host_inst(.I_SYS_CLK(clk), .I_RST_N(rst_h_n), .BUS(link_if.host),
		.I_CMD_VALID(valid), .I_CMD_WRITE(wr), .I_CMD_TWO(two), .I_CMD_REG(creg), .I_CMD_WDATA(wdata),
		.I_MCLK_RUN(run), .O_CMD_READY(ready), .O_CMD_DONE(done), .O_NACK(nack), .O_RDATA(rdata), .O_EOC(eoc_h));
	aicp_link_properties aicp_link_properties_inst(.I_SYS_CLK(clk), .I_RST_N(rst_n),
		.i_host_scl_o(link_if.host_scl_o), .i_host_scl_oe_n(link_if.host_scl_oe_n),
		.i_host_sda_o(link_if.host_sda_o), .i_host_sda_oe_n(link_if.host_sda_oe_n),
		.i_dev_sda_o(link_if.dev_sda_o), .i_dev_sda_oe_n(link_if.dev_sda_oe_n),
		.i_scl(link_if.scl), .i_sda(link_if.sda), .i_mclk(link_if.mclk),
		.i_master_reset_n(link_if.master_reset_n), .i_eoc(link_if.eoc));

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cmd(input logic w, input logic t, input logic [7:0] r, input logic [7:0] d);
		int k;
		for (k = 0; k < 1000 && ready !== 1'b1; k++) cycles(1);
		check(ready, 1'b1, "ready");
		wr = w;
		two = t;
		creg = r;
		wdata = d;
		valid = 1'b1;
		cycles(1);
		valid = 1'b0;
		for (k = 0; k < 20000 && done !== 1'b1; k++) cycles(1);
		check(done, 1'b1, "done");
		check(nack, 1'b0, "nack");
	endtask
	task automatic rd(input logic t, input logic [7:0] r, input logic [15:0] exp);
		cmd(1'b0, t, r, 8'h00);
		check(rdata, exp, "read data");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		check(cfg, CFG_RESET, "config after reset");
		rd(1'b0, REG_CFG, {8'h00, CFG_RESET});
	endtask
	task automatic t_no_start();
		cmd(1'b1, 1'b0, REG_CFG, 8'h04);
		check(cfg, 8'h04, "config");
		cycles(600);
		check(busy, 1'b0, "busy without start");
		check(eoc_h, 1'b0, "eoc without start");
		cmd(1'b1, 1'b0, REG_RES_LO, 8'h5A);
		rd(1'b1, REG_RES_LO, 16'h0004);
	endtask
	task automatic t_convert(input logic [1:0] osr, input logic div, input logic keep, input logic [15:0] smp);
		int n, k, lim;
		logic [7:0] c;
		logic m;
		c = {osr, 1'b1, 2'b00, div, 2'b00};
		n = 64 << {osr[0], osr[1]};
		lim = n * 2 * MH * (div ? 1 : 2) - TAIL;
		sample = smp;
		run = keep;
		cmd(1'b1, 1'b0, REG_CFG, c);
		for (k = 0; k < lim + 2000 && eoc_h !== 1'b1; k++) cycles(1);
		check(eoc_h, 1'b1, "eoc");
		check(k > lim - 32 && k < lim + 32, 1'b1, "conversion length");
		sample = ~smp;
		cycles(2);
		m = link_if.mclk;
		cycles(3 * MH);
		check(link_if.mclk !== m, keep, "master clock");
		rd(1'b1, REG_RES_HI, smp);
		check(link_if.eoc, 1'b1, "eoc level");
	endtask
	task automatic t_abort();
		cmd(1'b1, 1'b0, REG_CFG, 8'hE0);
		check(busy, 1'b1, "busy");
		cmd(1'b1, 1'b0, REG_CFG, 8'hC0);
		check(busy, 1'b0, "abort");
		check(eoc_h, 1'b0, "eoc after abort");
	endtask
	task automatic t_pin_reset();
		rst_h_n = 1'b0;
		cycles(2);
		rst_h_n = 1'b1;
		cycles(RESET_PULSE_CYC + 4);
		check(cfg, CFG_RESET, "config after pin reset");
		check(busy, 1'b0, "busy after pin reset");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and main sequence
	initial begin
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (99000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		rst_h_n = 1'b1;
		t_reset();
		t_no_start();
		t_convert(2'b00, 1'b1, 1'b0, 16'hA53C);
		t_convert(2'b10, 1'b0, 1'b1, 16'h5AC3);
		t_abort();
		t_pin_reset();
		give_verdict();
	end
endmodule
